// ===== rtl/isc_shell_ctrl.sv
// Register bank and control for the messaging shell, Avalon-MM slave.
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "isc_defines.svh"
module isc_shell_ctrl (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [11:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire isc_pkg::isc_word_t avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output isc_pkg::isc_word_t avsReadData,
    output logic avsWaitRequest,
    output logic [1:0] avsResponse,
    input wire isc_pkg::isc_word_t pciAddr,
    input wire logic pciImageHit,
    input wire logic shellAccess,
    input wire logic translationEnable,
    input wire isc_pkg::isc_bsize_t imageBlockSize,
    output logic pciRetry,
    output isc_pkg::isc_word_t pbAddr,
    input wire logic inboundPostListNotEmpty,
    input wire logic outboundFreeListNotEmpty,
    input wire logic bottomReadIpl,
    input wire logic bottomReadOfl,
    input wire isc_pkg::isc_word_t iplBottomPointer,
    input wire isc_pkg::isc_word_t oflBottomPointer,
    output isc_pkg::isc_word_t bottomReadData,
    input wire logic hostIndexLoad,
    input wire isc_pkg::isc_word_t hostIndexLoadValue,
    input wire logic hostIndexIncrement,
    output isc_pkg::isc_word_t hostOutboundIndex,
    output logic [15:0] hostListEntries,
    output logic shellEnable,
    output logic extendedOutboundEnable,
    output logic irq
);
    import isc_pkg::*;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [15:0] translation_address_q, translation_address_d;
    logic shellEn_q, shellEn_d;
    logic extEn_q, extEn_d;
    logic empty_read_response_select_q, empty_read_response_select_d;
    isc_hopl_t hopl_q, hopl_d;
    logic [`ISC_IRQ_BITS-1:0] irqStat_q, irqStat_d;
    logic [`ISC_IRQ_BITS-1:0] irqMask_q, irqMask_d;
    logic iplSync1_q, iplSync2_q, iplSync3_q;
    logic oflSync1_q, oflSync2_q, oflSync3_q;
    logic ipl_q, ipl_d, ofl_q, ofl_d;
    isc_bus_state_t state_q, state_d;
    isc_word_t rdata_q, rdata_d;
    logic [1:0] resp_q, resp_d;
    isc_word_t bottom_q, bottom_d;
    isc_word_t csrView;
    logic [`ISC_IRQ_BITS-1:0] events;
    logic accessTaken;
    logic hit;

    // ------------------------------------------------------------------
    // Status inputs cross from the FIFO logic of another domain.
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            iplSync1_q <= 1'b0;
            iplSync2_q <= 1'b0;
            iplSync3_q <= 1'b0;
            oflSync1_q <= 1'b0;
            oflSync2_q <= 1'b0;
            oflSync3_q <= 1'b0;
        end else begin
            iplSync1_q <= inboundPostListNotEmpty;
            iplSync2_q <= iplSync1_q;
            iplSync3_q <= iplSync2_q;
            oflSync1_q <= outboundFreeListNotEmpty;
            oflSync2_q <= oflSync1_q;
            oflSync3_q <= oflSync2_q;
        end
    end

    always_comb begin
        ipl_d = ipl_q;
        ofl_d = ofl_q;
        if (iplSync2_q == iplSync3_q) begin
            ipl_d = iplSync3_q;
        end
        if (oflSync2_q == oflSync3_q) begin
            ofl_d = oflSync3_q;
        end
    end

    // ------------------------------------------------------------------
    // Bus slave: one wait cycle, answer on the second edge.
    // ------------------------------------------------------------------
    assign accessTaken = (state_q == ISC_ACK);
    assign avsWaitRequest = (avsRead || avsWrite) && !accessTaken;

    always_comb begin
        csrView = `ISC_ZERO32;
        csrView[`ISC_BIT_EN] = shellEn_q;
        csrView[`ISC_BIT_XEN] = extEn_q;
        csrView[`ISC_BIT_IPL] = ipl_q;
        csrView[`ISC_BIT_OFL] = ofl_q;
        csrView[`ISC_BIT_EMPTY_READ_RESPONSE_SELECT] = empty_read_response_select_q;
        csrView[`ISC_HOPL_HI:`ISC_HOPL_LO] = hopl_q;
    end

    always_comb begin
        state_d = ISC_IDLE;
        rdata_d = rdata_q;
        resp_d = resp_q;
        hit = 1'b1;
        if ((avsRead || avsWrite) && state_q == ISC_IDLE) begin
            state_d = ISC_ACK;
            unique case (avsAddress)
                `ISC_OFS_TRANSLATION_ADDRESS: rdata_d = {translation_address_q, 16'h0000};
                `ISC_OFS_CSR: rdata_d = csrView;
                `ISC_OFS_IRQ_STAT: rdata_d = {28'h0000000, irqStat_q};
                `ISC_OFS_IRQ_MASK: rdata_d = {28'h0000000, irqMask_q};
                default: begin
                    rdata_d = `ISC_ZERO32;
                    hit = 1'b0;
                end
            endcase
            // Unmapped words answer with a slave error and read as zero.
            resp_d = hit ? 2'b00 : 2'b10;
        end
    end

    // ------------------------------------------------------------------
    // Register writes, with byte enables.
    // ------------------------------------------------------------------
    always_comb begin
        translation_address_d = translation_address_q;
        shellEn_d = shellEn_q;
        extEn_d = extEn_q;
        empty_read_response_select_d = empty_read_response_select_q;
        hopl_d = hopl_q;
        irqMask_d = irqMask_q;
        events = {ofl_d & ~ofl_q, ipl_d & ~ipl_q, ofl_q & ~ofl_d,
                  ipl_q & ~ipl_d};
        irqStat_d = irqStat_q;
        if (avsWrite && accessTaken) begin
            unique case (avsAddress)
                `ISC_OFS_TRANSLATION_ADDRESS: begin
                    if (avsByteEnable[2]) begin
                        translation_address_d[7:0] = avsWriteData[23:16];
                    end
                    if (avsByteEnable[3]) begin
                        translation_address_d[15:8] = avsWriteData[31:24];
                    end
                end
                `ISC_OFS_CSR: begin
                    // Both list status bits are read-only.
                    if (avsByteEnable[0]) begin
                        shellEn_d = avsWriteData[`ISC_BIT_EN];
                        extEn_d = avsWriteData[`ISC_BIT_XEN];
                        empty_read_response_select_d = avsWriteData[`ISC_BIT_EMPTY_READ_RESPONSE_SELECT];
                        hopl_d = avsWriteData[`ISC_HOPL_HI:`ISC_HOPL_LO];
                    end
                end
                `ISC_OFS_IRQ_STAT: begin
                    if (avsByteEnable[0]) begin
                        irqStat_d = irqStat_q &
                            ~avsWriteData[`ISC_IRQ_BITS-1:0];
                    end
                end
                `ISC_OFS_IRQ_MASK: begin
                    if (avsByteEnable[0]) begin
                        irqMask_d = avsWriteData[`ISC_IRQ_BITS-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // A new event wins over a clear in the same cycle.
        irqStat_d = irqStat_d | events;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            translation_address_q <= 16'h0000;
            shellEn_q <= 1'b0;
            extEn_q <= 1'b0;
            empty_read_response_select_q <= 1'b0;
            hopl_q <= `ISC_HOPL_256;
            irqStat_q <= '0;
            irqMask_q <= '0;
            ipl_q <= 1'b0;
            ofl_q <= 1'b0;
            state_q <= ISC_IDLE;
            rdata_q <= `ISC_ZERO32;
            resp_q <= 2'b00;
            bottom_q <= `ISC_ZERO32;
        end else begin
            translation_address_q <= translation_address_d;
            shellEn_q <= shellEn_d;
            extEn_q <= extEn_d;
            empty_read_response_select_q <= empty_read_response_select_d;
            hopl_q <= hopl_d;
            irqStat_q <= irqStat_d;
            irqMask_q <= irqMask_d;
            ipl_q <= ipl_d;
            ofl_q <= ofl_d;
            state_q <= state_d;
            rdata_q <= rdata_d;
            resp_q <= resp_d;
            bottom_q <= bottom_d;
        end
    end

    // ------------------------------------------------------------------
    // Bottom pointer reads from the IOP.
    // ------------------------------------------------------------------
    always_comb begin
        bottom_d = bottom_q;
        if (bottomReadIpl) begin
            bottom_d = (empty_read_response_select_q && !ipl_q) ? `ISC_EMPTY_READ
                                          : iplBottomPointer;
        end else if (bottomReadOfl) begin
            bottom_d = (empty_read_response_select_q && !ofl_q) ? `ISC_EMPTY_READ
                                          : oflBottomPointer;
        end
    end

    // ------------------------------------------------------------------
    // Outputs and the two sub-blocks.
    // ------------------------------------------------------------------
    // Retry is combinational so the PCI target can stop in the same phase.
    assign pciRetry = pciImageHit && !shellEn_q;
    assign avsReadData = rdata_q;
    assign avsResponse = resp_q;
    assign bottomReadData = bottom_q;
    assign shellEnable = shellEn_q;
    assign extendedOutboundEnable = extEn_q;
    assign irq = |(irqStat_q & irqMask_q);

    isc_addr_xlate uXlate (
        .sys_clk(sys_clk),
        .rst(rst),
        .pciAddr(pciAddr),
        .translationEnable(translationEnable),
        .imageBlockSize(imageBlockSize),
        .shellAccess(shellAccess),
        .translationAddress(translation_address_q),
        .pbAddr(pbAddr)
    );

    isc_host_index uIndex (
        .sys_clk(sys_clk),
        .rst(rst),
        .enable(extEn_q),
        .listSize(hopl_q),
        .indexLoad(hostIndexLoad),
        .indexLoadValue(hostIndexLoadValue),
        .indexIncrement(hostIndexIncrement),
        .hostOutboundIndex(hostOutboundIndex),
        .listEntries(hostListEntries)
    );
endmodule // isc_shell_ctrl
`default_nettype wire

// ===== rtl/isc_defines.svh
// Register offsets, field positions and fixed values of the shell control block.
`ifndef ISC_DEFINES_SVH
`define ISC_DEFINES_SVH
`define ISC_OFS_TRANSLATION_ADDRESS 12'h504
`define ISC_OFS_CSR 12'h508
`define ISC_OFS_IRQ_STAT 12'h540
`define ISC_OFS_IRQ_MASK 12'h544
`define ISC_BIT_EN 0
`define ISC_BIT_XEN 1
`define ISC_BIT_IPL 2
`define ISC_BIT_OFL 3
`define ISC_BIT_EMPTY_READ_RESPONSE_SELECT 4
`define ISC_HOPL_LO 5
`define ISC_HOPL_HI 7
`define ISC_TRANSLATION_ADDRESS_LO 16
`define ISC_TRANSLATION_ADDRESS_HI 31
`define ISC_EMPTY_READ 32'hffff_ffff
`define ISC_ZERO32 32'h0000_0000
`define ISC_HOPL_256 3'h0
`define ISC_HOPL_256B 3'h1
`define ISC_HOPL_1K 3'h2
`define ISC_HOPL_4K 3'h4
`define ISC_IDX_LO 2
`define ISC_IDX_HI_256 9
`define ISC_IDX_HI_1K 11
`define ISC_IDX_HI_4K 13
`define ISC_IRQ_BITS 4
`endif

// ===== rtl/isc_pkg.sv
// Types shared by the shell control block.
package isc_pkg;
    typedef logic [31:0] isc_word_t;
    typedef logic [3:0] isc_bsize_t;
    typedef logic [2:0] isc_hopl_t;
    typedef enum logic [1:0] {
        ISC_IDLE = 2'b00,
        ISC_ACK = 2'b01
    } isc_bus_state_t;
endpackage

// ===== rtl/isc_addr_xlate.sv
// Upper address substitution for the messaging target image.
`timescale 1ns/1ps
`default_nettype none
`include "isc_defines.svh"
module isc_addr_xlate (
    input wire logic sys_clk,
    input wire logic rst,
    input wire isc_pkg::isc_word_t pciAddr,
    input wire logic translationEnable,
    input wire isc_pkg::isc_bsize_t imageBlockSize,
    input wire logic shellAccess,
    input wire logic [15:0] translationAddress,
    output isc_pkg::isc_word_t pbAddr
);
    import isc_pkg::*;

    isc_word_t pbAddr_d;
    isc_word_t pbAddr_q;
    logic [15:0] keepMask;

    // Code n keeps the low n address bits of the upper half from the PCI side.
    always_comb begin
        keepMask = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            if (i < int'(imageBlockSize)) begin
                keepMask[i] = 1'b1;
            end
        end
        pbAddr_d = pciAddr;
        if (translationEnable && !shellAccess) begin
            pbAddr_d[`ISC_TRANSLATION_ADDRESS_HI:`ISC_TRANSLATION_ADDRESS_LO] =
                (pciAddr[`ISC_TRANSLATION_ADDRESS_HI:`ISC_TRANSLATION_ADDRESS_LO] & keepMask) |
                (translationAddress & ~keepMask);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pbAddr_q <= `ISC_ZERO32;
        end else begin
            pbAddr_q <= pbAddr_d;
        end
    end

    assign pbAddr = pbAddr_q;
endmodule // isc_addr_xlate
`default_nettype wire

// ===== rtl/isc_host_index.sv
// Host outbound index counter that wraps at the programmed list size.
`timescale 1ns/1ps
`default_nettype none
`include "isc_defines.svh"
module isc_host_index (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic enable,
    input wire isc_pkg::isc_hopl_t listSize,
    input wire logic indexLoad,
    input wire isc_pkg::isc_word_t indexLoadValue,
    input wire logic indexIncrement,
    output isc_pkg::isc_word_t hostOutboundIndex,
    output logic [15:0] listEntries
);
    import isc_pkg::*;

    isc_word_t index_d;
    isc_word_t index_q;
    isc_word_t wrapMask;
    isc_word_t bumped;

    always_comb begin
        unique case (listSize)
            `ISC_HOPL_1K: begin
                wrapMask = 32'h0000_0ffc;
                listEntries = 16'h0400;
            end
            `ISC_HOPL_4K: begin
                wrapMask = 32'h0000_3ffc;
                listEntries = 16'h1000;
            end
            default: begin
                wrapMask = 32'h0000_03fc;
                listEntries = 16'h0100;
            end
        endcase
        bumped = index_q + 32'h0000_0004;
        index_d = index_q;
        if (indexLoad) begin
            index_d = indexLoadValue;
        end else if (indexIncrement && enable) begin
            // Bits outside the wrap field stay put so the list base stays in place.
            index_d = (index_q & ~wrapMask) | (bumped & wrapMask);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            index_q <= `ISC_ZERO32;
        end else begin
            index_q <= index_d;
        end
    end

    assign hostOutboundIndex = index_q;
endmodule // isc_host_index
`default_nettype wire

// ===== tb/isc_shell_ctrl_asserts.sv
// Port-level assertions for the shell control block.
`timescale 1ns/1ps
`default_nettype none
module isc_shell_ctrl_asserts (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic avsWaitRequest,
    input wire isc_pkg::isc_word_t pciAddr,
    input wire logic pciImageHit,
    input wire logic shellAccess,
    input wire logic translationEnable,
    input wire logic pciRetry,
    input wire isc_pkg::isc_word_t pbAddr,
    input wire logic hostIndexIncrement,
    input wire isc_pkg::isc_word_t hostOutboundIndex,
    input wire logic [15:0] hostListEntries,
    input wire logic shellEnable,
    input wire logic extendedOutboundEnable,
    input wire logic irq
);
    import isc_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    property p_wait;
        (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state too long");
    property p_retry;
        pciImageHit |-> pciRetry == !shellEnable;
    endproperty
    a_retry: assert property (p_retry) else $error("retry wrong");
    property p_shell;
        shellAccess |=> pbAddr == $past(pciAddr);
    endproperty
    a_shell: assert property (p_shell) else $error("shell xlated");
    property p_pass;
        !translationEnable |=> pbAddr == $past(pciAddr);
    endproperty
    a_pass: assert property (p_pass) else $error("addr changed");
    property p_hold;
        hostIndexIncrement && !extendedOutboundEnable |=>
            $stable(hostOutboundIndex);
    endproperty
    a_hold: assert property (p_hold) else $error("index moved");
    property p_wrap;
        hostIndexIncrement && extendedOutboundEnable &&
            hostListEntries == 16'h0100 |=>
            hostOutboundIndex[9:2] == $past(hostOutboundIndex[9:2]) + 8'h01;
    endproperty
    a_wrap: assert property (p_wrap) else $error("index step");
    property p_entries;
        hostListEntries inside {16'h0100, 16'h0400, 16'h1000};
    endproperty
    a_entries: assert property (p_entries) else $error("size");
    property p_rst;
        $fell(rst) |-> !shellEnable && !extendedOutboundEnable && !irq;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    c_retry: cover property (pciRetry);
    c_wrap: cover property (hostIndexIncrement && extendedOutboundEnable);
    c_shell: cover property (shellAccess && translationEnable);
endmodule // isc_shell_ctrl_asserts
bind isc_shell_ctrl isc_shell_ctrl_asserts isc_shell_ctrl_asserts_i (
    .sys_clk, .rst, .avsRead, .avsWrite, .avsWaitRequest, .pciAddr,
    .pciImageHit, .shellAccess, .translationEnable, .pciRetry, .pbAddr,
    .hostIndexIncrement, .hostOutboundIndex, .hostListEntries, .shellEnable,
    .extendedOutboundEnable, .irq
);
`default_nettype wire

// ===== tb/isc_list_model.sv
// Behavioural model of the processor-side message lists.
`timescale 1ns/1ps
`default_nettype none
module isc_list_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic postIpl,
    input wire logic postOfl,
    input wire logic bottomReadIpl,
    input wire logic bottomReadOfl,
    output logic inboundPostListNotEmpty,
    output logic outboundFreeListNotEmpty,
    output isc_pkg::isc_word_t iplBottomPointer,
    output isc_pkg::isc_word_t oflBottomPointer
);
    import isc_pkg::*;
    logic [7:0] iplCount_q;
    logic [7:0] oflCount_q;
    wire popIpl = bottomReadIpl && inboundPostListNotEmpty;
    wire popOfl = bottomReadOfl && outboundFreeListNotEmpty;
    // A bottom read takes a frame only when one is there.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            iplCount_q <= 8'h00;
            oflCount_q <= 8'h00;
            iplBottomPointer <= 32'h0000_1000;
            oflBottomPointer <= 32'h0000_2000;
        end else begin
            iplCount_q <= iplCount_q + 8'(postIpl) - 8'(popIpl);
            oflCount_q <= oflCount_q + 8'(postOfl) - 8'(popOfl);
            iplBottomPointer <= iplBottomPointer + (popIpl ? 32'h4 : 32'h0);
            oflBottomPointer <= oflBottomPointer + (popOfl ? 32'h4 : 32'h0);
        end
    end
    assign inboundPostListNotEmpty = iplCount_q != 8'h00;
    assign outboundFreeListNotEmpty = oflCount_q != 8'h00;
endmodule // isc_list_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the shell control block.
`timescale 1ns/1ps
`default_nettype none
`include "isc_defines.svh"
`define CHK(nm, ex, gt) begin \
    checks = checks + 1; \
    if ((gt) !== (ex)) begin \
        nFail = nFail + 1; \
        $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); \
    end \
end
module testbench;
    import isc_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, avsRead = 1'b0, avsWrite = 1'b0;
    logic pciImageHit = 1'b0, shellAccess = 1'b0, translationEnable = 1'b0;
    logic bottomReadIpl = 1'b0, bottomReadOfl = 1'b0, postIpl = 1'b0;
    logic postOfl = 1'b0, hostIndexLoad = 1'b0, hostIndexIncrement = 1'b0;
    logic [11:0] avsAddress = 12'h000;
    logic [3:0] avsByteEnable = 4'hf;
    isc_word_t avsWriteData = 32'h0, pciAddr = 32'h0;
    isc_word_t hostIndexLoadValue = 32'h0;
    isc_bsize_t imageBlockSize = 4'h0;
    isc_word_t avsReadData, pbAddr, bottomReadData, hostOutboundIndex, q, ex;
    isc_word_t iplBottomPointer, oflBottomPointer;
    logic avsWaitRequest, pciRetry, shellEnable, extendedOutboundEnable, irq;
    logic inboundPostListNotEmpty, outboundFreeListNotEmpty, irqSeen;
    logic [1:0] avsResponse, rsp;
    logic [15:0] hostListEntries;
    int nFail = 0, checks = 0, cycles = 0;
    isc_shell_ctrl isc_shell_ctrl_i (
        .sys_clk, .rst, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
        .avsByteEnable, .avsReadData, .avsWaitRequest, .avsResponse,
        .pciAddr, .pciImageHit, .shellAccess, .translationEnable,
        .imageBlockSize, .pciRetry, .pbAddr, .inboundPostListNotEmpty,
        .outboundFreeListNotEmpty, .bottomReadIpl, .bottomReadOfl,
        .iplBottomPointer, .oflBottomPointer, .bottomReadData, .hostIndexLoad,
        .hostIndexLoadValue, .hostIndexIncrement, .hostOutboundIndex,
        .hostListEntries, .shellEnable, .extendedOutboundEnable, .irq
    );
    isc_list_model isc_list_model_i (
        .sys_clk, .rst, .postIpl, .postOfl, .bottomReadIpl, .bottomReadOfl,
        .inboundPostListNotEmpty, .outboundFreeListNotEmpty,
        .iplBottomPointer, .oflBottomPointer
    );
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            nFail = nFail + 1;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, nFail);
        if (nFail == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input isc_word_t d);
        @(posedge sys_clk);
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= wr;
        avsRead <= !wr;
        @(posedge sys_clk iff avsWaitRequest === 1'b0);
        q = avsReadData;
        rsp = avsResponse;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input isc_word_t e, input string nm);
        bus(1'b0, a, 32'h0);
        `CHK(nm, e, q)
    endtask
    task automatic pop(input logic outbound_free_list_not_empty, input isc_word_t e, input string nm);
        @(posedge sys_clk);
        {bottomReadOfl, bottomReadIpl} <= outbound_free_list_not_empty ? 2'b10 : 2'b01;
        @(posedge sys_clk);
        {bottomReadOfl, bottomReadIpl} <= 2'b00;
        @(negedge sys_clk);
        `CHK(nm, e, bottomReadData)
    endtask
    task automatic strobe(input logic [3:0] m);
        @(posedge sys_clk);
        {hostIndexIncrement, hostIndexLoad, postOfl, postIpl} <= m;
        @(posedge sys_clk);
        {hostIndexIncrement, hostIndexLoad, postOfl, postIpl} <= 4'h0;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        rd(`ISC_OFS_TRANSLATION_ADDRESS, 32'h0, "translation_address reset");
        rd(`ISC_OFS_CSR, 32'h0, "csr reset");
        rd(12'h100, 32'h0, "unmapped read");
        `CHK("unmapped resp", 2'b10, rsp)
        bus(1'b1, `ISC_OFS_TRANSLATION_ADDRESS, 32'habcd_0000);
        rd(`ISC_OFS_TRANSLATION_ADDRESS, 32'habcd_0000, "translation_address");
        // Only lane 2 is enabled, so the upper byte must keep its value.
        avsByteEnable <= 4'h4;
        bus(1'b1, `ISC_OFS_TRANSLATION_ADDRESS, 32'h5512_0000);
        avsByteEnable <= 4'hf;
        rd(`ISC_OFS_TRANSLATION_ADDRESS, 32'hab12_0000, "translation_address lane");
        bus(1'b1, `ISC_OFS_TRANSLATION_ADDRESS, 32'habcd_0000);
        bus(1'b1, `ISC_OFS_CSR, 32'h0000_00ff);
        rd(`ISC_OFS_CSR, 32'h0000_00f3, "csr fields");
        `CHK("enables", 2'b11, {shellEnable, extendedOutboundEnable})
        pciAddr <= 32'h1234_5678;
        translationEnable <= 1'b1;
        for (int n = 0; n < 16; n++) begin
            imageBlockSize <= n[3:0];
            repeat (2) @(posedge sys_clk);
            q = ((32'h1 << n) - 32'h1) << 16;
            ex = (32'habcd_0000 & ~q) | (32'h1234_5678 & (q | 32'hffff));
            `CHK("xlate", ex, pbAddr)
        end
        shellAccess <= 1'b1;
        repeat (2) @(posedge sys_clk);
        `CHK("shell access", 32'h1234_5678, pbAddr)
        shellAccess <= 1'b0;
        translationEnable <= 1'b0;
        pciImageHit <= 1'b1;
        repeat (2) @(posedge sys_clk);
        `CHK("no xlate", 32'h1234_5678, pbAddr)
        `CHK("retry enabled", 1'b0, pciRetry)
        bus(1'b1, `ISC_OFS_CSR, 32'h0);
        @(negedge sys_clk);
        `CHK("retry disabled", 1'b1, pciRetry)
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, `ISC_OFS_CSR, 32'h0000_0010);
            pop(k[0], 32'hffff_ffff, "empty ones");
            bus(1'b1, `ISC_OFS_CSR, 32'h0);
            ex = k ? oflBottomPointer : iplBottomPointer;
            pop(k[0], ex, "empty pointer");
            strobe(k ? 4'h2 : 4'h1);
            repeat (6) @(posedge sys_clk);
            rd(`ISC_OFS_CSR, k ? 32'h8 : 32'h4, "list status");
            bus(1'b1, `ISC_OFS_CSR, 32'h0000_0010);
            pop(k[0], ex, "full pointer");
            repeat (6) @(posedge sys_clk);
        end
        rd(`ISC_OFS_IRQ_STAT, 32'hf, "irq events");
        bus(1'b1, `ISC_OFS_IRQ_MASK, 32'h0);
        @(negedge sys_clk);
        irqSeen = irq;
        bus(1'b1, `ISC_OFS_IRQ_MASK, 32'hf);
        @(negedge sys_clk);
        `CHK("irq mask", 1'b1, irq ^ irqSeen)
        bus(1'b1, `ISC_OFS_IRQ_STAT, 32'hf);
        rd(`ISC_OFS_IRQ_STAT, 32'h0, "irq clear");
        `CHK("irq low", 1'b0, irq)
        for (int s = 0; s < 3; s++) begin
            bus(1'b1, `ISC_OFS_CSR, {24'h0, 3'(2 * s), 5'b00010});
            q = ((32'h1 << (8 + 2 * s)) - 32'h1) << 2;
            hostIndexLoadValue <= 32'h5550_0000 | q;
            strobe(4'h4);
            strobe(4'h8);
            @(negedge sys_clk);
            `CHK("index wrap", 32'h5550_0000, hostOutboundIndex)
            `CHK("entries", 16'h0100 << (2 * s), hostListEntries)
        end
        bus(1'b1, `ISC_OFS_CSR, 32'h0);
        strobe(4'h8);
        @(negedge sys_clk);
        `CHK("index held", 32'h5550_0000, hostOutboundIndex)
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
